/* hw/mbp_pwm.v */
// Operation
// - Count is compared against seven match registers driving outputs and actions
// - Period match resets the count and starts a new cycle
// - Single-edge output edge position set by its own match register
// - Single-edge outputs rise at each cycle start unless constant low
// - Double-edge output uses two matches; order sets pulse polarity
// - Six single-edge, up to five double-edge outputs (outputs 1 to 5), or a mix
// - Each match may stop, reset or interrupt per configuration
// - Released match values apply only at cycle boundary, no glitch
// - Period and width are whole timer counts; common repetition rate
// - Timer mode counts clock; counter mode counts capture input edges
// - Without PWM mode acts as 32-bit timer with 32-bit prescaler
`timescale 1ns/100ps
`include "mbp_regs.vh"
module mbp_pwm
#(
   parameter CW = `MBP_CNT_W,
   parameter NM = `MBP_NUM_MATCH,
   parameter NO = `MBP_NUM_OUT
)
(
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Control
   input wire count_enable,
   input wire count_reset,
   input wire pwm_mode,
   input wire counter_mode,
   input wire [1:0] cap_edge_sel,
   input wire [1:0] cap_sel,
   input wire [3:0] cap_in,
   input wire [CW-1:0] prescale,
   // Match programming
   input wire [NM-1:0] match_wr,
   input wire [CW-1:0] match_wdata,
   input wire [NM-1:0] match_release,
   input wire [3*NM-1:0] match_action,
   // Output configuration
   input wire [NO-1:0] out_enable,
   input wire [NO-1:0] out_double_edge,
   // Status and outputs
   output reg [CW-1:0] count,
   output reg [CW-1:0] prescale_count,
   output reg [NM-1:0] match_event,
   output wire [NM-1:0] match_irq,
   output reg counting,
   output wire [NO-1:0] pwm_out
);
   // Per-match slices in g_match feed hit, reset_req and stop_req; g_cap feeds cap_hist
   wire [NM-1:0] hit;
   wire [NM-1:0] reset_req;
   wire [NM-1:0] stop_req;
   wire [3:0] cap_hist;
   wire any_reset;
   wire any_stop;
   wire period_hit;
   wire presc_wrap;
   wire cap_sig;
   wire cap_d;
   wire cap_edge;
   reg cap_valid;
   reg tick;
   reg stopped;
   reg next_stopped;
   reg next_counting;
   reg [CW-1:0] next_count;
   reg [CW-1:0] next_prescale_count;
   genvar g;

   // Every capture pin keeps its own history, so moving cap_sel
   // never compares one pin against another and fakes an edge
   generate
      for (g = 0; g < 4; g = g + 1)
      begin : g_cap
         reg last;

         always @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               last <= 1'b0;
            else
               last <= cap_in[g];
         end

         assign cap_hist[g] = last;
      end
   endgenerate

   // Pins are synchronous; one cycle of history finds the edge. No edge
   // counts until the history holds a real sample, so a pin idling high
   // cannot fake a rising edge right after reset
   assign cap_sig = cap_in[cap_sel];
   assign cap_d = cap_hist[cap_sel];
   assign cap_edge = cap_valid &
      ((cap_edge_sel[`MBP_CAP_RISE] & cap_sig & ~cap_d) |
      (cap_edge_sel[`MBP_CAP_FALL] & ~cap_sig & cap_d));

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         cap_valid <= 1'b0;
      else
         cap_valid <= 1'b1;
   end

   // Prescaler wraps when its count reaches the programmed value
   assign presc_wrap = (prescale_count == prescale);

   // Prescaler only runs while counting in timer mode; counter mode bypasses it
   always @*
   begin
      next_prescale_count = prescale_count;
      if (count_reset)
         next_prescale_count = `MBP_CNT_RST;
      else if (counting && !counter_mode)
      begin
         if (presc_wrap)
            next_prescale_count = `MBP_CNT_RST;
         else
            next_prescale_count = prescale_count + 1'b1;
      end
   end

   // Tick source: prescaled clock in timer mode, input edges in counter mode
   always @*
   begin
      tick = 1'b0;
      if (counting)
      begin
         if (counter_mode)
            tick = cap_edge;
         else
            tick = presc_wrap;
      end
   end

   // One slice per match register: software shadow, active copy seen by
   // the comparator, release flag, and the actions the match requests
   generate
      for (g = 0; g < NM; g = g + 1)
      begin : g_match
         reg [CW-1:0] shadow;
         reg [CW-1:0] active;
         reg pending;

         // Compare only on a tick, so a count held over many clocks matches once
         assign hit[g] = tick && (count == active);
         assign reset_req[g] = hit[g] & match_action[3*g+`MBP_ACT_RESET];
         assign stop_req[g] = hit[g] & match_action[3*g+`MBP_ACT_STOP];
         assign match_irq[g] = match_event[g] & match_action[3*g+`MBP_ACT_IRQ];

         always @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               shadow <= `MBP_MATCH_RST;
            else if (match_wr[g])
               shadow <= match_wdata;
         end

         // A plain timer takes writes at once; PWM mode waits for the period
         // match so a pulse is never cut short mid-cycle
         always @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               active <= `MBP_MATCH_RST;
            else if (!pwm_mode)
            begin
               if (match_wr[g])
                  active <= match_wdata;
            end
            else if (period_hit && pending)
               active <= shadow;
         end

         // Release is remembered until the next period match applies it
         always @(posedge clk or negedge rst_b)
         begin
            if (!rst_b)
               pending <= 1'b0;
            else if (!pwm_mode)
               pending <= 1'b0;
            else if (match_release[g])
               pending <= 1'b1;
            else if (period_hit)
               pending <= 1'b0;
         end
      end
   endgenerate

   // Period match always restarts the cycle in PWM mode
   assign period_hit = pwm_mode & hit[0];

   // Any match asking for a reset restarts the count; reset beats stop
   assign any_reset = (|reset_req) | period_hit;
   assign any_stop = |stop_req;

   // Main count: clear, restart on a reset match, freeze on a stop match,
   // else step on each tick
   always @*
   begin
      next_count = count;
      if (count_reset)
         next_count = `MBP_CNT_RST;
      else if (any_reset)
         next_count = `MBP_CNT_RST;
      else if (any_stop)
         next_count = count;
      else if (tick)
         next_count = count + 1'b1;
   end

   // A stop stays in force until count_reset; counting alone would
   // follow count_enable again on the very next cycle
   always @*
   begin
      next_stopped = stopped;
      if (count_reset)
         next_stopped = 1'b0;
      else if (any_stop)
         next_stopped = 1'b1;
   end

   always @*
   begin
      next_counting = count_enable & ~next_stopped;
   end

   // Registers follow the next-state logic above
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         count <= `MBP_CNT_RST;
      else
         count <= next_count;
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         prescale_count <= `MBP_CNT_RST;
      else
         prescale_count <= next_prescale_count;
   end

   // Counting follows count_enable unless a stop match froze the timer
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         counting <= 1'b0;
         stopped <= 1'b0;
      end
      else
      begin
         counting <= next_counting;
         stopped <= next_stopped;
      end
   end

   // Events stand for one cycle, in step with the output edges they cause
   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         match_event <= {NM{1'b0}};
      else
         match_event <= hit;
   end

   // Output n: single edge rises at the period match and falls at match n+1.
   // Double edge (n >= 1) rises at match n and falls at match n+1; whichever
   // comes first in the cycle decides the pulse polarity. Output 0 has no
   // spare rise match, so it is always single edge
   generate
      for (g = 0; g < NO; g = g + 1)
      begin : g_out
         wire dbl;
         wire out_on;
         wire rise_hit;
         wire fall_hit;

         assign dbl = out_double_edge[g] & (g != 0);
         assign out_on = out_enable[g] & pwm_mode;
         assign rise_hit = hit[g];
         assign fall_hit = hit[g+1];

         mbp_pwm_out u_out
         (
            .clk(clk),
            .rst_b(rst_b),
            .cycle_start(period_hit),
            .enable(out_on),
            .double_edge(dbl),
            .set_match(rise_hit),
            .clr_match(fall_hit),
            .pwm(pwm_out[g])
         );
      end
   endgenerate
endmodule

/* hw/mbp_regs.vh */
`ifndef MBP_REGS_VH
`define MBP_REGS_VH
`define MBP_NUM_MATCH 7
`define MBP_NUM_OUT 6
`define MBP_CNT_W 32
`define MBP_ACT_STOP 0
`define MBP_ACT_RESET 1
`define MBP_ACT_IRQ 2
`define MBP_CNT_RST 32'h00000000
`define MBP_MATCH_RST 32'h00000000
`define MBP_CAP_RISE 0
`define MBP_CAP_FALL 1
`endif

/* hw/mbp_pwm_out.v */
`timescale 1ns/100ps
module mbp_pwm_out
(
   // Clock and reset
   input wire clk,
   input wire rst_b,
   // Cycle control
   input wire cycle_start,
   input wire enable,
   input wire double_edge,
   input wire set_match,
   input wire clr_match,
   // Output
   output reg pwm
);
   reg next_pwm;

   always @*
   begin
      next_pwm = pwm;
      if (!enable)
         next_pwm = 1'b0;
      else if (double_edge)
      begin
         // Clear wins when both edges coincide: avoids a stray one-count pulse
         if (clr_match)
            next_pwm = 1'b0;
         else if (set_match)
            next_pwm = 1'b1;
      end
      else
      begin
         if (clr_match)
            next_pwm = 1'b0;
         else if (cycle_start)
            next_pwm = 1'b1;
      end
   end

   always @(posedge clk or negedge rst_b)
   begin
      if (!rst_b)
         pwm <= 1'b0;
      else
         pwm <= next_pwm;
   end
endmodule

/* dv/mbp_pwm_checker.sv */
`timescale 1ns/100ps
module mbp_pwm_checker
#(
   parameter CW = 32,
   parameter NM = 7,
   parameter NO = 6
)
(
   // Clock and control
   input logic clk,
   input logic rst_b,
   input logic count_reset,
   input logic counter_mode,
   input logic pwm_mode,
   input logic [CW-1:0] prescale,
   input logic [3*NM-1:0] match_action,
   input logic [NO-1:0] out_enable,
   // Status
   input logic [CW-1:0] count,
   input logic [CW-1:0] prescale_count,
   input logic [NM-1:0] match_event,
   input logic [NM-1:0] match_irq,
   input logic counting,
   input logic [NO-1:0] pwm_out
);
   default clocking @(posedge clk); endclocking
   default disable iff (!rst_b);
   wire run = !count_reset && !counter_mode;
   chk_irq_gate: assert property (match_irq[0] == (match_event[0] && match_action[2]))
      else $error("irq gate wrong");
   chk_reset_hold: assert property (count_reset |=> count == 0 && prescale_count == 0)
      else $error("reset hold wrong");
   chk_count_hold: assert property (run && prescale_count != prescale |=> $stable(count))
      else $error("count moved early");
   chk_presc_wrap: assert property (
      run && counting && prescale_count == prescale |=> prescale_count == 0)
      else $error("prescaler no wrap");
   chk_period_zero: assert property (
      $past(pwm_mode) && pwm_mode && match_event[0] |-> count == 0)
      else $error("period no reset");
   chk_single_rise: assert property (
      $past(pwm_mode) && pwm_mode && match_event[0] && !match_event[1]
      && out_enable[0] |-> pwm_out[0])
      else $error("no rise");
   chk_single_fall: assert property (
      pwm_mode && match_event[1] && out_enable[0] |-> !pwm_out[0])
      else $error("no fall");
   chk_event_pulse: assert property (pwm_mode && match_event[0] |=> !match_event[0])
      else $error("event too long");
   cover property (pwm_mode && match_event[1]);
   cover property (match_irq[0]);
   cover property (counter_mode && count == 3);
endmodule

/* dv/mbp_pwm_load.sv */
`timescale 1ns/100ps
module mbp_pwm_load
(
   // Clock and sensed pin
   input wire clk,
   input wire pwm,
   input wire mark,
   // Last full cycle
   output reg [31:0] per,
   output reg [31:0] hi
);
   reg [31:0] pc;
   reg [31:0] hc;
   // Passive load, so only measures
   always @(posedge clk)
   begin
      per <= mark ? pc : per;
      hi <= mark ? hc : hi;
      pc <= mark ? 32'h1 : pc + 32'h1;
      hc <= (mark ? 32'h0 : hc) + {31'h0, pwm};
   end
endmodule

/* dv/mbp_pwm_tb.sv */
`timescale 1ns/100ps
`define CHK(a, e) begin checks++; if ((a) !== (e)) begin num_errors++; \
   $display("[FAIL] %0t mismatch", $time); end end
module mbp_pwm_tb;
   logic clk, rst_b, count_reset, pwm_mode, counter_mode, counting;
   logic [1:0] cap_edge_sel;
   logic [3:0] cap_in;
   logic [31:0] prescale, match_wdata, count, prescale_count, per, hi;
   logic [6:0] match_wr, match_release, match_event, match_irq;
   logic [5:0] pwm_out;
   logic [20:0] act;
   integer seed = 1;
   int num_errors = 0, checks = 0, p, pr, w, n;
   mbp_pwm i_mbp_pwm (.clk(clk), .rst_b(rst_b), .count_enable(1'b1),
      .count_reset(count_reset), .pwm_mode(pwm_mode), .counter_mode(counter_mode),
      .cap_edge_sel(cap_edge_sel), .cap_sel(cap_edge_sel), .cap_in(cap_in),
      .prescale(prescale), .match_wr(match_wr), .match_wdata(match_wdata),
      .match_release(match_release), .match_action(act), .out_enable(6'h01),
      .out_double_edge(6'h00), .count(count), .prescale_count(prescale_count),
      .match_event(match_event), .match_irq(match_irq), .counting(counting),
      .pwm_out(pwm_out));
   mbp_pwm_load i_mbp_pwm_load (.clk(clk), .pwm(pwm_out[0]), .mark(match_event[0]),
      .per(per), .hi(hi));
   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end
   function int f_len(input int m, input int ps);
      return (m + 1) * (ps + 1);
   endfunction
   task results;
      $display("errors %0d checks %0d", num_errors, checks);
      if (num_errors == 0 && checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   task wm(input int i, input int v, input bit rel);
      @(posedge clk) match_wr <= 7'h01 << i;
      match_wdata <= v;
      @(posedge clk) match_wr <= 0;
      match_release <= rel ? 7'h01 << i : 0;
      @(posedge clk) match_release <= 0;
   endtask
   task periods(input int k);
      int t;
      repeat (k)
      begin
         t = 0;
         do begin @(posedge clk); #1; t++; end while (match_event[0] !== 1'b1 && t < 400);
         if (t >= 400) num_errors++;
      end
      @(posedge clk);
      #1;
   endtask
   initial
   begin
      rst_b = 0; count_reset = 0; pwm_mode = 0; counter_mode = 0; cap_edge_sel = 1;
      cap_in = 0; prescale = 0; match_wr = 0; match_wdata = 0; match_release = 0;
      act = 21'h000004;
      repeat (16) @(posedge clk);
      rst_b <= 1;
      for (int i = 0; i < 6; i++)
      begin
         p = {$random(seed)} % 4;
         pr = 4 + {$random(seed)} % 9;
         w = (i == 1) ? pr - 1 : 1 + {$random(seed)} % (pr - 1);
         wm(0, pr, 1);
         wm(1, w, 1);
         @(posedge clk) prescale <= p;
         count_reset <= 1;
         pwm_mode <= 1;
         @(posedge clk) count_reset <= 0;
         periods(3);
         `CHK(per, f_len(pr, p))
         `CHK(hi, f_len(w, p))
         wm(1, w + 1, 0);
         periods(3);
         `CHK(hi, f_len(w, p))
      end
      for (int s = 1; s < 3; s++)
      begin
         n = 1 + {$random(seed)} % 8;
         @(posedge clk) pwm_mode <= 0;
         counter_mode <= 1;
         cap_edge_sel <= s;
         count_reset <= 1;
         @(posedge clk) count_reset <= 0;
         repeat (n)
         begin
            repeat (2) @(posedge clk);
            cap_in[s] <= 1;
            repeat (2) @(posedge clk);
            cap_in[s] <= 0;
         end
         repeat (4) @(posedge clk);
         #1;
         `CHK(count, n)
      end
      @(posedge clk) counter_mode <= 0;
      prescale <= 0;
      act <= 21'h000044;
      wm(2, 9, 0);
      @(posedge clk) count_reset <= 1;
      @(posedge clk) count_reset <= 0;
      repeat (20) @(posedge clk);
      #1;
      `CHK(count, 9)
      `CHK(counting, 1'b0)
      results;
   end
   initial
   begin
      #1000000;
      num_errors++;
      results;
   end
endmodule
bind mbp_pwm mbp_pwm_checker #(.CW(CW), .NM(NM), .NO(NO)) i_mbp_pwm_checker (.clk(clk),
   .rst_b(rst_b), .count_reset(count_reset), .counter_mode(counter_mode),
   .pwm_mode(pwm_mode), .prescale(prescale), .match_action(match_action),
   .out_enable(out_enable), .count(count), .prescale_count(prescale_count),
   .match_event(match_event), .match_irq(match_irq), .counting(counting),
   .pwm_out(pwm_out));
